// >>> rtl/plc_params.svh
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH

// register port
`define PLC_ADDR_W          4
`define PLC_DATA_W          16
`define PLC_REG_CTRL        4'h0
`define PLC_REG_MODE        4'h1
`define PLC_REG_STAT        4'h2

// control register fields
`define PLC_CTRL_SRST       15
`define PLC_CTRL_LOOP       14
`define PLC_CTRL_SPD100     13
`define PLC_CTRL_ANEN       12
`define PLC_CTRL_PD         11
`define PLC_CTRL_ISO        10
`define PLC_CTRL_FDX        8
`define PLC_CTRL_RST_SPD100 1'b1
`define PLC_CTRL_RST_ANEN   1'b1

// mode register fields
`define PLC_MODE_REP        0
`define PLC_MODE_EDPD       1
`define PLC_MODE_EIM        2

// status register fields
`define PLC_STAT_EVT        0
`define PLC_STAT_ENERGY     1
`define PLC_STAT_LINK       2
`define PLC_STAT_CRS        3
`define PLC_STAT_POWERED    4
`define PLC_STAT_FAST       5
`define PLC_STAT_REGULATOR_OFF_STRAP     6
`define PLC_STAT_CLKMODE    7

// strap defaults: clock-mode strap pulled up, regulator strap pulled down
`define PLC_STRAP_RST_REGULATOR_OFF_STRAP  1'b0
`define PLC_STRAP_RST_CLKMODE 1'b1

// timing
`define PLC_CLK_MHZ         200
`define PLC_LINK_WAIT_US    330
`define PLC_LINK_WAIT_CYC   (`PLC_LINK_WAIT_US * `PLC_CLK_MHZ)
`define PLC_SLOW_RATE_US    16
`define PLC_SLOW_RATE_CYC   (`PLC_SLOW_RATE_US * `PLC_CLK_MHZ)
`define PLC_REFCLK_MHZ      50
`define PLC_REFCLK_HALF_CYC (`PLC_CLK_MHZ / (2 * `PLC_REFCLK_MHZ))
`define PLC_SRST_MAX_MS     500
`define PLC_BLINK_HALF_MS   50
`define PLC_BLINK_HALF_CYC  (`PLC_BLINK_HALF_MS * 1000 * `PLC_CLK_MHZ)
`define PLC_CNT_W           24

// 5b code groups, first bit received in the msb
`define PLC_SYM_T           5'b01101
`define PLC_SYM_R           5'b00111
`define PLC_SYM_I           5'b11111
`define PLC_SSD_JK          10'b1100010001

`endif

// >>> rtl/plc_pkg.sv
package plc_pkg;

  typedef enum logic [3:0] {
    PLC_LINK_DOWN  = 4'h1,
    PLC_LINK_WAIT  = 4'h2,
    PLC_LINK_READY = 4'h4,
    PLC_LINK_UP    = 4'h8
  } plc_link_state_t;

  typedef enum logic [4:0] {
    PLC_CRS_IDLE  = 5'h01,
    PLC_CRS_PRE   = 5'h02,
    PLC_CRS_STRM  = 5'h04,
    PLC_CRS_TPEND = 5'h08,
    PLC_CRS_IPEND = 5'h10
  } plc_crs_state_t;

  typedef struct packed {
    logic soft_reset;
    logic loopback;
    logic speed100;
    logic autoneg_en;
    logic power_down;
    logic isolate;
    logic full_duplex;
    logic repeater;
    logic energy_detect_powerdown_en;
    logic energy_irq_mask;
  } plc_ctrl_t;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [1:0] data;
  } plc_rmii_tx_t;

endpackage : plc_pkg

// >>> rtl/plc_top.sv
// Function
// - clock-out strap mode drives 50MHz reference clock; interrupt pin function withheld.
// - link/activity LED active with link, blinking while carrier sense is high.
// - speed LED active at 100Mbps, inactive at 10Mbps or while isolated.
// - regulator strap high makes link/activity LED active-low, else active-high.
// - clock-mode strap high makes speed LED active-low, else active-high.
// - power-down bit stops line transmit, line receive and link; clearing it auto-resets the datapath.
// - energy-detect power-down with no energy powers down and transmits nothing.
// - energy sets flag, powers up, restores state, interrupts when unmasked.
// - isolate ignores transmit inputs, keeps management; isolate resets to 0.
// - both resets clear registers; preserved bits survive soft reset; power-down clears none.
// - slow media rate for 16us after reset, then fast rate if autonegotiation on.
// - writing soft-reset bit starts reset; bit self-clears; done well within 0.5s.
// - repeater or full duplex: carrier from receive only; otherwise transmit or receive.
// - carrier starts on two non-contiguous zeros within ten received code bits.
// - ten consecutive ones before start-of-stream pair drop carrier.
// - after start pair, carrier holds until T or the first idle; an R or a second idle keeps it off.
// - 100 and 10 link status merge into one bit driving link LED.
// - wait 330us of valid waveform, then ready and up once autonegotiation is done, or straight to up with autonegotiation off.
// - valid waveform loss drops link at once; 10BASE-T uses its own receiver.
// - loopback returns transmit data to receive outputs; line transmitter stays off.
// - clock-mode strap latched at power-on and each hard reset release; default pulled up.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "plc_params.svh"

module plc_top #(
  parameter int LINK_WAIT_CYCLES  = `PLC_LINK_WAIT_CYC,
  parameter int BLINK_HALF_CYCLES = `PLC_BLINK_HALF_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic [`PLC_ADDR_W-1:0] reg_addr,
  input  wire logic [`PLC_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`PLC_DATA_W-1:0] reg_rdata,
  input  wire logic                   hard_reset_n,
  input  wire logic                   regulator_off_strap,
  input  wire logic                   clock_mode_strap,
  input  wire logic                   line_energy,
  input  wire plc_pkg::plc_rmii_tx_t  tx_in,
  input  wire logic [1:0]             rx_data_in,
  input  wire logic                   rx_dv_in,
  input  wire logic                   rx_code_bit,
  input  wire logic                   rx_bit_valid,
  input  wire logic                   data_valid,
  input  wire logic                   an_done,
  input  wire logic                   link10_in,
  output logic [1:0]                  rx_data_out,
  output logic                        rx_dv_out,
  output logic                        line_tx_en,
  output logic [1:0]                  line_tx_data,
  output logic                        crs_out,
  output logic                        link_activity_led,
  output logic                        speed_led,
  output logic                        ref_clock_out,
  output logic                        irq_out_n,
  output logic                        mii_fast_rate
);

  // pin synchronisers: {line_energy, clock_mode_strap, regulator_off_strap, hard_reset_n}
  logic [3:0] meta_q;
  logic [3:0] sync_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= {line_energy, clock_mode_strap, regulator_off_strap, hard_reset_n};
      sync_q <= meta_q;
    end
  end

  // hard reset held until the pin has crossed both stages
  wire rst_all = sys_rst | ~sync_q[0];

  // strap capture at power-on and at each hard reset release
  logic strap_pend_q;
  logic regulator_off_strap_q;
  logic clkmode_q;

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      // pull defaults stand during reset; the pins are taken on the first free edge
      strap_pend_q <= 1'b1;
      regulator_off_strap_q     <= `PLC_STRAP_RST_REGULATOR_OFF_STRAP;
      clkmode_q    <= `PLC_STRAP_RST_CLKMODE;
    end else if (strap_pend_q) begin
      strap_pend_q <= 1'b0;
      regulator_off_strap_q     <= sync_q[1];
      clkmode_q    <= sync_q[2];
    end
  end

  // register decode
  plc_pkg::plc_ctrl_t ctrl_q;
  logic               srst_q;
  logic               energy_evt_q;
  wire                wr_ctrl = reg_wr && (reg_addr == `PLC_REG_CTRL);
  wire                wr_mode = reg_wr && (reg_addr == `PLC_REG_MODE);
  wire                wr_stat = reg_wr && (reg_addr == `PLC_REG_STAT);
  wire                srst_req = wr_ctrl && reg_wdata[`PLC_CTRL_SRST];

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      ctrl_q             <= '0;
      ctrl_q.speed100    <= `PLC_CTRL_RST_SPD100;
      ctrl_q.autoneg_en  <= `PLC_CTRL_RST_ANEN;
      srst_q             <= 1'b0;
    end else if (srst_q) begin
      // preserved bits (energy-detect enable, interrupt mask) survive
      ctrl_q.soft_reset  <= 1'b0;
      ctrl_q.loopback    <= 1'b0;
      ctrl_q.speed100    <= `PLC_CTRL_RST_SPD100;
      ctrl_q.autoneg_en  <= `PLC_CTRL_RST_ANEN;
      ctrl_q.power_down  <= 1'b0;
      ctrl_q.isolate     <= 1'b0;
      ctrl_q.full_duplex <= 1'b0;
      ctrl_q.repeater    <= 1'b0;
      srst_q             <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_q.soft_reset  <= reg_wdata[`PLC_CTRL_SRST];
      ctrl_q.loopback    <= reg_wdata[`PLC_CTRL_LOOP];
      ctrl_q.speed100    <= reg_wdata[`PLC_CTRL_SPD100];
      ctrl_q.autoneg_en  <= reg_wdata[`PLC_CTRL_ANEN];
      ctrl_q.power_down  <= reg_wdata[`PLC_CTRL_PD];
      ctrl_q.isolate     <= reg_wdata[`PLC_CTRL_ISO];
      ctrl_q.full_duplex <= reg_wdata[`PLC_CTRL_FDX];
      srst_q             <= srst_req;
    end else if (wr_mode) begin
      ctrl_q.repeater                   <= reg_wdata[`PLC_MODE_REP];
      ctrl_q.energy_detect_powerdown_en <= reg_wdata[`PLC_MODE_EDPD];
      ctrl_q.energy_irq_mask            <= reg_wdata[`PLC_MODE_EIM];
    end
  end

  // power control; no register is touched by either power-down mode
  logic powered_q;
  logic pd_prev_q;
  logic energy_prev_q;
  wire  energy_present = sync_q[3];
  wire  edpd_off = ctrl_q.energy_detect_powerdown_en && !energy_present;
  wire  pd_fall = pd_prev_q && !ctrl_q.power_down;
  wire  energy_rise = energy_present && !energy_prev_q;
  // datapath state is rebuilt after any power-up, keeping config untouched
  wire  dp_rst = rst_all || srst_q || pd_fall || !powered_q;

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      powered_q     <= 1'b0;
      pd_prev_q     <= 1'b0;
      energy_prev_q <= 1'b0;
      energy_evt_q  <= 1'b0;
    end else begin
      powered_q     <= !ctrl_q.power_down && !edpd_off;
      pd_prev_q     <= ctrl_q.power_down;
      energy_prev_q <= energy_present;
      // set wins over the write-one clear
      if (energy_rise) begin
        energy_evt_q <= 1'b1;
      end else if (wr_stat && reg_wdata[`PLC_STAT_EVT]) begin
        energy_evt_q <= 1'b0;
      end
    end
  end

  // slow media rate window after reset
  logic [`PLC_CNT_W-1:0] rate_cnt_q;
  wire                   rate_done = (rate_cnt_q == `PLC_CNT_W'(`PLC_SLOW_RATE_CYC));

  always_ff @(posedge sys_clk) begin
    if (rst_all || srst_q) begin
      rate_cnt_q    <= '0;
      mii_fast_rate <= 1'b0;
    end else begin
      if (!rate_done) begin
        rate_cnt_q <= rate_cnt_q + `PLC_CNT_W'(1);
      end
      mii_fast_rate <= rate_done && ctrl_q.autoneg_en;
    end
  end

  // transmit path: isolation masks the MAC, loopback keeps the line quiet
  wire plc_pkg::plc_rmii_tx_t tx_eff = ctrl_q.isolate ? '0 : tx_in;
  wire tx_line_ok = powered_q && !ctrl_q.loopback;

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      line_tx_en   <= 1'b0;
      line_tx_data <= 2'h0;
      rx_data_out  <= 2'h0;
      rx_dv_out    <= 1'b0;
    end else begin
      line_tx_en   <= tx_line_ok && tx_eff.en;
      line_tx_data <= tx_line_ok ? tx_eff.data : 2'h0;
      if (ctrl_q.loopback) begin
        rx_data_out <= tx_eff.data;
        rx_dv_out   <= tx_eff.en;
      end else begin
        rx_data_out <= powered_q ? rx_data_in : 2'h0;
        rx_dv_out   <= powered_q && rx_dv_in;
      end
    end
  end

  // receive carrier detection on the 5b code stream
  plc_pkg::plc_crs_state_t crs_st_q;
  plc_pkg::plc_crs_state_t crs_st_d;
  logic [9:0]              hist_q;
  logic [2:0]              sym_cnt_q;
  wire  [9:0]              hist_sh = {hist_q[8:0], rx_code_bit};
  wire                     zero_pair = !hist_sh[0] && (hist_sh[9:2] != 8'hff);
  wire                     ones10 = &hist_sh;
  wire                     ssd_seen = (hist_sh == `PLC_SSD_JK);
  wire                     sym_done = (sym_cnt_q == 3'h4);
  wire  [4:0]              sym = hist_sh[4:0];
  wire                     in_stream = crs_st_q[2] || crs_st_q[3] || crs_st_q[4];

  always_comb begin
    crs_st_d = crs_st_q;
    case (crs_st_q)
      plc_pkg::PLC_CRS_IDLE: begin
        if (zero_pair) crs_st_d = plc_pkg::PLC_CRS_PRE;
      end
      plc_pkg::PLC_CRS_PRE: begin
        if (ssd_seen) crs_st_d = plc_pkg::PLC_CRS_STRM;
        else if (ones10) crs_st_d = plc_pkg::PLC_CRS_IDLE;
      end
      plc_pkg::PLC_CRS_STRM: begin
        if (sym_done && sym == `PLC_SYM_T) crs_st_d = plc_pkg::PLC_CRS_TPEND;
        else if (sym_done && sym == `PLC_SYM_I) crs_st_d = plc_pkg::PLC_CRS_IPEND;
      end
      plc_pkg::PLC_CRS_TPEND: begin
        if (sym_done) begin
          crs_st_d = (sym == `PLC_SYM_R) ? plc_pkg::PLC_CRS_IDLE : plc_pkg::PLC_CRS_STRM;
        end
      end
      plc_pkg::PLC_CRS_IPEND: begin
        if (sym_done) begin
          crs_st_d = (sym == `PLC_SYM_I) ? plc_pkg::PLC_CRS_IDLE : plc_pkg::PLC_CRS_STRM;
        end
      end
      default: crs_st_d = plc_pkg::PLC_CRS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (dp_rst) begin
      crs_st_q  <= plc_pkg::PLC_CRS_IDLE;
      hist_q    <= 10'h3ff;
      sym_cnt_q <= 3'h0;
    end else if (rx_bit_valid) begin
      crs_st_q  <= crs_st_d;
      hist_q    <= hist_sh;
      if (!in_stream || sym_done) sym_cnt_q <= 3'h0;
      else sym_cnt_q <= sym_cnt_q + 3'h1;
    end
  end

  // carrier drops tentatively on T or the first idle, returns if not confirmed
  wire rx_crs = crs_st_q[1] || crs_st_q[2];
  wire rx_only = ctrl_q.full_duplex || ctrl_q.repeater;
  wire crs_d = rx_crs || (!rx_only && tx_eff.en);

  // link monitor
  plc_pkg::plc_link_state_t link_st_q;
  plc_pkg::plc_link_state_t link_st_d;
  logic [`PLC_CNT_W-1:0]    link_cnt_q;
  wire                      wait_done = (link_cnt_q == `PLC_CNT_W'(LINK_WAIT_CYCLES - 1));

  always_comb begin
    link_st_d = link_st_q;
    case (link_st_q)
      plc_pkg::PLC_LINK_DOWN: begin
        if (data_valid) link_st_d = plc_pkg::PLC_LINK_WAIT;
      end
      plc_pkg::PLC_LINK_WAIT: begin
        if (!data_valid) link_st_d = plc_pkg::PLC_LINK_DOWN;
        else if (wait_done) begin
          link_st_d = ctrl_q.autoneg_en ? plc_pkg::PLC_LINK_READY : plc_pkg::PLC_LINK_UP;
        end
      end
      plc_pkg::PLC_LINK_READY: begin
        if (!data_valid) link_st_d = plc_pkg::PLC_LINK_DOWN;
        else if (an_done || !ctrl_q.autoneg_en) link_st_d = plc_pkg::PLC_LINK_UP;
      end
      plc_pkg::PLC_LINK_UP: begin
        if (!data_valid) link_st_d = plc_pkg::PLC_LINK_DOWN;
      end
      default: link_st_d = plc_pkg::PLC_LINK_DOWN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (dp_rst || !ctrl_q.speed100) begin
      link_st_q  <= plc_pkg::PLC_LINK_DOWN;
      link_cnt_q <= '0;
    end else begin
      link_st_q  <= link_st_d;
      link_cnt_q <= (link_st_q == plc_pkg::PLC_LINK_WAIT) ? link_cnt_q + `PLC_CNT_W'(1) : '0;
    end
  end

  // one link bit for both speeds
  wire link_ok = powered_q && (ctrl_q.speed100 ? link_st_q[3] : link10_in);

  // slow blink; the rate is a parameter so simulation can shorten it
  logic [`PLC_CNT_W-1:0] blink_cnt_q;
  logic                  blink_q;
  wire                   blink_wrap = (blink_cnt_q == `PLC_CNT_W'(BLINK_HALF_CYCLES - 1));

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else begin
      blink_cnt_q <= blink_wrap ? '0 : blink_cnt_q + `PLC_CNT_W'(1);
      if (blink_wrap) blink_q <= !blink_q;
    end
  end

  // reference clock divider, free running from the system clock
  logic refdiv_q;
  logic crs_q;
  logic link_q;

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      refdiv_q          <= 1'b0;
      ref_clock_out     <= 1'b0;
      irq_out_n         <= 1'b1;
      crs_out           <= 1'b0;
      crs_q             <= 1'b0;
      link_q            <= 1'b0;
      link_activity_led <= 1'b0;
      speed_led         <= 1'b0;
    end else begin
      refdiv_q <= refdiv_q + 1'b1;
      if (!clkmode_q && refdiv_q == 1'(`PLC_REFCLK_HALF_CYC - 1)) begin
        ref_clock_out <= !ref_clock_out;
      end else if (clkmode_q) begin
        ref_clock_out <= 1'b0;
      end
      // interrupt pin function exists only in clock-in mode
      irq_out_n <= !(clkmode_q && energy_evt_q && ctrl_q.energy_irq_mask);
      crs_out   <= crs_d;
      crs_q     <= crs_d;
      link_q    <= link_ok;
      link_activity_led <= (link_ok && !(crs_d && blink_q)) ^ regulator_off_strap_q;
      speed_led <= (ctrl_q.speed100 && !ctrl_q.isolate) ^ clkmode_q;
    end
  end

  // register read, valid only in the cycle after the strobe
  wire [`PLC_DATA_W-1:0] ctrl_img = {ctrl_q.soft_reset, ctrl_q.loopback, ctrl_q.speed100, ctrl_q.autoneg_en,
                                     ctrl_q.power_down, ctrl_q.isolate, 1'b0, ctrl_q.full_duplex, 8'h00};
  wire [`PLC_DATA_W-1:0] mode_img = {13'h0000, ctrl_q.energy_irq_mask, ctrl_q.energy_detect_powerdown_en,
                                     ctrl_q.repeater};
  wire [`PLC_DATA_W-1:0] stat_img = {8'h00, clkmode_q, regulator_off_strap_q, mii_fast_rate, powered_q, crs_q, link_q,
                                     energy_present, energy_evt_q};
  wire [`PLC_DATA_W-1:0] rd_mux = (reg_addr == `PLC_REG_CTRL) ? ctrl_img :
                                  (reg_addr == `PLC_REG_MODE) ? mode_img :
                                  (reg_addr == `PLC_REG_STAT) ? stat_img : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (rst_all) reg_rdata <= 16'h0000;
    else reg_rdata <= reg_rd ? rd_mux : 16'h0000;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst_all);

  property p_refclk_no_irq;
    !clkmode_q |=> irq_out_n;
  endproperty
  a_refclk_no_irq: assert property (p_refclk_no_irq) else $error("irq active in clock-out mode");

  property p_speed_led;
    ##1 speed_led == ($past(ctrl_q.speed100 && !ctrl_q.isolate) ^ $past(clkmode_q));
  endproperty
  a_speed_led: assert property (p_speed_led) else $error("speed led wrong level");

  property p_link_led;
    !crs_d && !$past(strap_pend_q) |=> link_activity_led == ($past(link_ok) ^ regulator_off_strap_q);
  endproperty
  a_link_led: assert property (p_link_led) else $error("link led wrong level");

  property p_isolate;
    ctrl_q.isolate && !ctrl_q.loopback && !rx_crs |=> !line_tx_en && !crs_out;
  endproperty
  a_isolate: assert property (p_isolate) else $error("transmit used while isolated");

  property p_loopback;
    ctrl_q.loopback |=> !line_tx_en && (rx_dv_out == $past(tx_eff.en));
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback path wrong");

  property p_srst;
    srst_q |=> !srst_q && !ctrl_q.soft_reset && !ctrl_q.isolate && !rate_done;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset not completed");

  property p_edpd;
    edpd_off |=> !powered_q ##1 !line_tx_en;
  endproperty
  a_edpd: assert property (p_edpd) else $error("powered without line energy");

  property p_link_drop;
    link_st_q == plc_pkg::PLC_LINK_UP && !data_valid && !dp_rst && ctrl_q.speed100
      |=> link_st_q == plc_pkg::PLC_LINK_DOWN;
  endproperty
  a_link_drop: assert property (p_link_drop) else $error("link held after waveform loss");

  property p_link_wait;
    $rose(link_st_q == plc_pkg::PLC_LINK_READY) |-> $past(link_cnt_q) == `PLC_CNT_W'(LINK_WAIT_CYCLES - 1);
  endproperty
  a_link_wait: assert property (p_link_wait) else $error("link ready too early");

  property p_crs_rx_only;
    rx_only && !rx_crs |=> !crs_out;
  endproperty
  a_crs_rx_only: assert property (p_crs_rx_only) else $error("carrier from transmit in rx-only mode");

  property p_slow_rate;
    !rate_done |=> !mii_fast_rate;
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("fast rate inside slow window");

  c_link_up: cover property (link_st_q == plc_pkg::PLC_LINK_UP);
  c_stream: cover property (crs_st_q == plc_pkg::PLC_CRS_TPEND ##[1:20] crs_st_q == plc_pkg::PLC_CRS_IDLE);
  c_energy_irq: cover property (!irq_out_n);
  c_soft_reset: cover property (srst_q);

endmodule : plc_top

// >>> test/plc_mac_model.sv
`timescale 1ns/10ps
module plc_mac_model (
  input  wire logic             sys_clk,
  input  wire logic             send,
  input  wire logic [1:0]       data,
  output plc_pkg::plc_rmii_tx_t tx
);
  initial tx = '0;
  // idle data lines invert their previous value every cycle so stale data is never mistaken for valid
  always @(posedge sys_clk) begin
    tx.en <= send;
    tx.er <= 1'b0;
    tx.data <= send ? data : ~tx.data;
  end
endmodule : plc_mac_model

// >>> test/test_phy_mode_link_control.sv
`timescale 1ns/10ps
`include "plc_params.svh"
module test_phy_mode_link_control;
  logic        sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, hard_reset_n = 1'b1;
  logic        regulator_off_strap = 1'b0, clock_mode_strap = 1'b0, line_energy = 1'b0, send = 1'b0;
  logic        rx_dv_in = 1'b0, rx_code_bit = 1'b1, rx_bit_valid = 1'b0, data_valid = 1'b0;
  logic        an_done = 1'b0, link10_in = 1'b0, rx_dv_out, line_tx_en, crs_out, link_activity_led;
  logic        speed_led, ref_clock_out, irq_out_n, mii_fast_rate, p;
  logic [1:0]  sdata = 2'h1, rx_data_in = 2'h0, rx_data_out, line_tx_data;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, v;
  int          n_errors = 0, check_count = 0, cnt;
  plc_pkg::plc_rmii_tx_t tx;

  plc_top #(.LINK_WAIT_CYCLES(20), .BLINK_HALF_CYCLES(4)) plc_top_inst (
    .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hard_reset_n,
    .regulator_off_strap, .clock_mode_strap, .line_energy, .tx_in(tx), .rx_data_in, .rx_dv_in,
    .rx_code_bit, .rx_bit_valid, .data_valid, .an_done, .link10_in, .rx_data_out, .rx_dv_out,
    .line_tx_en, .line_tx_data, .crs_out, .link_activity_led, .speed_led, .ref_clock_out,
    .irq_out_n, .mii_fast_rate);
  plc_mac_model plc_mac_model_inst (.sys_clk, .send, .data(sdata), .tx);

  always #2.5 sys_clk = ~sys_clk;

  task automatic final_report;
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample mid-cycle there
  task automatic rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata & m, e);
    @(posedge sys_clk);
  endtask : rc

  task automatic bits(input logic [9:0] b, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      rx_bit_valid <= 1'b1;
      rx_code_bit <= b[i];
      @(posedge sys_clk);
    end
    rx_bit_valid <= 1'b0;
  endtask : bits

  task automatic wait_led;
    for (int i = 0; i < 100 && link_activity_led !== 1'b1; i++) @(posedge sys_clk);
    if (link_activity_led !== 1'b1) begin
      n_errors++;
      final_report();
    end
  endtask : wait_led

  initial begin
    cyc(10);
    sys_rst <= 1'b0;
    cyc(3);
    chk(16'(mii_fast_rate), 16'h0);
    rc(`PLC_REG_CTRL, 16'hffff, 16'h3000);
    rc(`PLC_REG_STAT, 16'h00c0, 16'h0000);
    rc(4'h3, 16'hffff, 16'h0000);
    cnt = 0;
    p = ref_clock_out;
    repeat (40) begin
      @(negedge sys_clk);
      if (ref_clock_out && !p) cnt++;
      p = ref_clock_out;
    end
    chk(16'(cnt), 16'h000a);
    @(posedge sys_clk);
    data_valid <= 1'b1;
    cyc(30);
    rc(`PLC_REG_STAT, 16'h0004, 16'h0000);
    an_done <= 1'b1;
    wait_led();
    chk(16'(link_activity_led), 16'h1);
    chk(16'(speed_led), 16'h1);
    rc(`PLC_REG_STAT, 16'h0004, 16'h0004);
    bits(10'h002, 3);
    cyc(2);
    chk(16'(crs_out), 16'h1);
    cnt = 0;
    p = link_activity_led;
    repeat (12) begin
      @(posedge sys_clk);
      if (link_activity_led !== p) cnt++;
      p = link_activity_led;
    end
    chk(16'(cnt > 0), 16'h1);
    bits(10'h3ff, 10);
    cyc(2);
    chk(16'(crs_out), 16'h0);
    data_valid <= 1'b0;
    cyc(3);
    chk(16'(link_activity_led), 16'h0);
    send <= 1'b1;
    sdata <= 2'h2;
    cyc(3);
    chk(16'(line_tx_en), 16'h1);
    chk(16'(line_tx_data), 16'h2);
    chk(16'(crs_out), 16'h1);
    wr(`PLC_REG_CTRL, 16'h3100);
    cyc(3);
    chk(16'(crs_out), 16'h0);
    wr(`PLC_REG_CTRL, 16'h3400);
    cyc(2);
    chk({14'h0, line_tx_en, speed_led}, 16'h0);
    wr(`PLC_REG_CTRL, 16'h7000);
    cyc(2);
    chk(16'(line_tx_en), 16'h0);
    chk({13'h0, rx_dv_out, rx_data_out}, 16'h0006);
    wr(`PLC_REG_CTRL, 16'h3800);
    cyc(2);
    rc(`PLC_REG_STAT, 16'h0010, 16'h0000);
    chk(16'(line_tx_en), 16'h0);
    wr(`PLC_REG_CTRL, 16'h3000);
    cyc(4);
    chk(16'(line_tx_en), 16'h1);
    send <= 1'b0;
    wr(`PLC_REG_MODE, 16'h0006);
    line_energy <= 1'b1;
    cyc(4);
    rc(`PLC_REG_STAT, 16'h0003, 16'h0003);
    wr(`PLC_REG_STAT, 16'h0001);
    rc(`PLC_REG_STAT, 16'h0001, 16'h0000);
    chk(16'(irq_out_n), 16'h1);
    wr(`PLC_REG_CTRL, 16'h8400);
    cyc(4);
    rc(`PLC_REG_CTRL, 16'hffff, 16'h3000);
    rc(`PLC_REG_MODE, 16'h0006, 16'h0006);
    line_energy <= 1'b0;
    cyc(3300);
    chk(16'(mii_fast_rate), 16'h1);
    clock_mode_strap <= 1'b1;
    regulator_off_strap <= 1'b1;
    hard_reset_n <= 1'b0;
    cyc(4);
    hard_reset_n <= 1'b1;
    cyc(6);
    rc(`PLC_REG_STAT, 16'h00c0, 16'h00c0);
    rc(`PLC_REG_MODE, 16'hffff, 16'h0000);
    chk(16'(speed_led), 16'h0);
    chk(16'(link_activity_led), 16'h1);
    wr(`PLC_REG_MODE, 16'h0004);
    line_energy <= 1'b1;
    cyc(6);
    chk(16'(irq_out_n), 16'h0);
    link10_in <= 1'b1;
    wr(`PLC_REG_CTRL, 16'h0000);
    rc(`PLC_REG_STAT, 16'h0004, 16'h0004);
    chk(16'(speed_led), 16'h1);
    chk(16'(link_activity_led), 16'h0);
    final_report();
  end
endmodule : test_phy_mode_link_control
